// *** hdl/scc_regs.svh ***
// Purpose: Constants for the shared control and channel select registers
// Assumes: Byte-wide register access, 8-bit addresses
// Notes: Definitions only
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_ADDR_STRAP_OBS   8'h00
`define SCC_ADDR_STATUS      8'h05
`define SCC_ADDR_DIAG        8'h06
`define SCC_ADDR_LOOPBACK    8'h07
`define SCC_ADDR_CHSEL       8'hFF
`define SCC_RST_DIAG         8'h00
`define SCC_RST_LOOPBACK     8'h04
`define SCC_RST_CHSEL        8'h00
`define SCC_DIAG_UNLOCK      4'hA
`define SCC_ST_EE_DONE       4
`define SCC_ST_IRQ_A         3
`define SCC_ST_IRQ_B         2
`define SCC_LB_B_TO_A        1
`define SCC_LB_A_TO_B        0
`define SCC_CS_LOCK_HI       7
`define SCC_CS_LOCK_LO       6
`define SCC_CS_PIN_IRQ       5
`define SCC_CS_BCAST         3
`define SCC_CS_CHAN_EN       2
`define SCC_CS_TGT_HI        1
`define SCC_CS_TGT_LO        0
`define SCC_LOCK_OR          2'h0
`define SCC_LOCK_A           2'h1
`define SCC_LOCK_B           2'h2
`define SCC_LOCK_AND         2'h3
`define SCC_STRAP_POL        0
`define SCC_DIAG_HI          3
`define SCC_DIAG_LO          0
`endif

// *** hdl/scc_pkg.sv ***
// Purpose: Types for the shared control register block
// Assumes: Nothing
// Notes: Types only
package scc_pkg;
  typedef struct packed {
    logic [7:0] diag_r;
    logic [7:0] loopback_r;
    logic [7:0] chsel_r;
    logic       ee_done_r;
    logic       irq_a_r;
    logic       irq_b_r;
    logic [3:0] strap_r;
    logic       strap_taken_r;
    logic       lock_pin_r;
    logic       los_irq_pin_r;
    logic [7:0] rdata_r;
  } scc_state_t;
endpackage : scc_pkg

// *** hdl/scc_shared_ctrl.sv ***
// Purpose: Shared control registers and channel select routing
// Assumes: Host access port is a decoded byte read/write strobe
// Notes: Per-channel register sets live outside this block
`include "scc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module scc_shared_ctrl (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] addr_strap_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic [7:0] ch_rdata_in,
  input  wire logic       ee_load_done_in,
  input  wire logic       irq_a_in,
  input  wire logic       irq_b_in,
  input  wire logic       lock_a_in,
  input  wire logic       lock_b_in,
  input  wire logic       sig_absent_in,
  input  wire logic       irq_in,
  output logic [7:0]      rdata_out,
  output logic            ch_wr_a_out,
  output logic            ch_wr_b_out,
  output logic            ch_rd_out,
  output logic [1:0]      ch_tgt_out,
  output logic            lb_b_to_a_out,
  output logic            lb_a_to_b_out,
  output logic            lock_pin_out,
  output logic            signal_loss_or_irq_pin_out
);
  scc_pkg::scc_state_t st_r;
  scc_pkg::scc_state_t st_nxt;
  logic                shared_sel;
  logic                chan_sel;
  logic                chsel_wr;
  logic [1:0]          lock_fld;
  logic                strap_pol;
  logic                diag_open;

  // Lock pin source select with strap polarity
  function automatic logic lock_sel(input logic [1:0] fld, input logic a, input logic b,
                                    input logic inv);
    logic v;
    unique case (fld)
      `SCC_LOCK_OR:  v = a | b;
      `SCC_LOCK_A:   v = a;
      `SCC_LOCK_B:   v = b;
      `SCC_LOCK_AND: v = a & b;
    endcase
    return v ^ inv;
  endfunction : lock_sel

  assign lock_fld  = st_r.chsel_r[`SCC_CS_LOCK_HI:`SCC_CS_LOCK_LO];
  assign strap_pol = st_r.strap_r[`SCC_STRAP_POL];
  assign diag_open = (st_r.diag_r[`SCC_DIAG_HI:`SCC_DIAG_LO] == `SCC_DIAG_UNLOCK);

  assign chsel_wr   = wr_in && (addr_in == `SCC_ADDR_CHSEL);
  assign chan_sel   = st_r.chsel_r[`SCC_CS_CHAN_EN] && (addr_in != `SCC_ADDR_CHSEL);
  assign shared_sel = !chan_sel;
  assign ch_tgt_out = st_r.chsel_r[`SCC_CS_TGT_HI:`SCC_CS_TGT_LO];
  assign ch_rd_out  = rd_in && chan_sel;
  assign ch_wr_a_out = wr_in && chan_sel && !chsel_wr &&
                       (st_r.chsel_r[`SCC_CS_BCAST] || ch_tgt_out == 2'h0);
  assign ch_wr_b_out = wr_in && chan_sel && !chsel_wr &&
                       (st_r.chsel_r[`SCC_CS_BCAST] || ch_tgt_out == 2'h1);
  assign lb_b_to_a_out = st_r.loopback_r[`SCC_LB_B_TO_A];
  assign lb_a_to_b_out = st_r.loopback_r[`SCC_LB_A_TO_B];
  assign rdata_out     = st_r.rdata_r;
  assign lock_pin_out  = st_r.lock_pin_r;
  assign signal_loss_or_irq_pin_out = st_r.los_irq_pin_r;

  always_comb begin
    st_nxt = st_r;
    if (!st_r.strap_taken_r) begin
      st_nxt.strap_taken_r = 1'b1;
      st_nxt.strap_r       = addr_strap_in;
    end
    st_nxt.lock_pin_r    = lock_sel(lock_fld, lock_a_in, lock_b_in, strap_pol);
    st_nxt.los_irq_pin_r = st_r.chsel_r[`SCC_CS_PIN_IRQ] ? irq_in : sig_absent_in;
    if (ee_load_done_in) st_nxt.ee_done_r = 1'b1;
    if (irq_a_in) st_nxt.irq_a_r = 1'b1;
    if (irq_b_in) st_nxt.irq_b_r = 1'b1;
    if (chsel_wr) begin
      st_nxt.chsel_r = wdata_in;
    end else if (wr_in && shared_sel) begin
      unique case (addr_in)
        `SCC_ADDR_DIAG:     st_nxt.diag_r = wdata_in;
        `SCC_ADDR_LOOPBACK: st_nxt.loopback_r = wdata_in;
        default: ;
      endcase
    end
    st_nxt.rdata_r = 8'h00;
    if (rd_in && chan_sel) begin
      st_nxt.rdata_r = ch_rdata_in;
    end else if (rd_in) begin
      unique case (addr_in)
        `SCC_ADDR_STRAP_OBS:
          if (diag_open) st_nxt.rdata_r = {st_r.strap_r, 4'h0};
        `SCC_ADDR_STATUS:
          st_nxt.rdata_r = {3'h0, st_r.ee_done_r, st_r.irq_a_r, st_r.irq_b_r, 2'h0};
        `SCC_ADDR_DIAG:     st_nxt.rdata_r = st_r.diag_r;
        `SCC_ADDR_LOOPBACK: st_nxt.rdata_r = st_r.loopback_r;
        `SCC_ADDR_CHSEL:    st_nxt.rdata_r = st_r.chsel_r;
        default:            st_nxt.rdata_r = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_r            <= '0;
      st_r.diag_r     <= `SCC_RST_DIAG;
      st_r.loopback_r <= `SCC_RST_LOOPBACK;
      st_r.chsel_r    <= `SCC_RST_CHSEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_ee_flag_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ee_load_done_in |=> st_r.ee_done_r) else $error("load flag not set");
  a_irq_flags: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    irq_a_in && irq_b_in |=> st_r.irq_a_r && st_r.irq_b_r) else $error("irq flag lost");
  a_strap_hidden: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rd_in && shared_sel && addr_in == `SCC_ADDR_STRAP_OBS && !diag_open
    |=> rdata_out == 8'h00) else $error("strap leaked");
  a_strap_shown: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rd_in && shared_sel && addr_in == `SCC_ADDR_STRAP_OBS && diag_open
    |=> rdata_out == {$past(st_r.strap_r), 4'h0}) else $error("strap not shown");

  // Loopback controls
  a_loop_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && shared_sel && addr_in == `SCC_ADDR_LOOPBACK
    |=> lb_a_to_b_out == $past(wdata_in[`SCC_LB_A_TO_B])) else $error("loopback not written");
  a_loop_b_to_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && shared_sel && addr_in == `SCC_ADDR_LOOPBACK
    |=> lb_b_to_a_out == $past(wdata_in[`SCC_LB_B_TO_A])) else $error("loopback b bad");

  // Lock pin, strap low
  a_lock_or: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_OR && !strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == ($past(lock_a_in) | $past(lock_b_in))) else $error("lock or bad");
  a_lock_chan_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_A && !strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == $past(lock_a_in)) else $error("lock a bad");
  a_lock_chan_b: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_B && !strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == $past(lock_b_in)) else $error("lock b bad");
  a_lock_and: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_AND && !strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == ($past(lock_a_in) & $past(lock_b_in))) else $error("lock and bad");

  // Lock pin, strap high
  a_lock_nor: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_OR && strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == !($past(lock_a_in) | $past(lock_b_in))) else $error("lock nor bad");
  a_lock_inv_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_A && strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == !$past(lock_a_in)) else $error("lock not a bad");
  a_lock_inv_b: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_B && strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == !$past(lock_b_in)) else $error("lock not b bad");
  a_lock_nand: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    lock_fld == `SCC_LOCK_AND && strap_pol && $stable(st_r.chsel_r)
    |=> lock_pin_out == !($past(lock_a_in) & $past(lock_b_in))) else $error("lock nand bad");

  // Shared status pin function
  a_pin_mux: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    st_r.chsel_r[`SCC_CS_PIN_IRQ]
    |=> signal_loss_or_irq_pin_out == $past(irq_in)) else $error("pin mux bad");
  a_pin_los: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !st_r.chsel_r[`SCC_CS_PIN_IRQ]
    |=> signal_loss_or_irq_pin_out == $past(sig_absent_in)) else $error("pin los bad");

  // Channel routing
  a_bcast_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && chan_sel && st_r.chsel_r[`SCC_CS_BCAST]
    |-> ch_wr_a_out && ch_wr_b_out) else $error("no bcast");
  a_bcast_none: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && chan_sel && !st_r.chsel_r[`SCC_CS_BCAST]
    |-> !(ch_wr_a_out && ch_wr_b_out)) else $error("stray bcast");
  a_chan_rd_data: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ch_rd_out |=> rdata_out == $past(ch_rdata_in)) else $error("chan read lost");
  a_shared_route: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !st_r.chsel_r[`SCC_CS_CHAN_EN]
    |-> !ch_rd_out && !ch_wr_a_out && !ch_wr_b_out) else $error("chan hit in shared");
  a_tgt_a_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && chan_sel && !st_r.chsel_r[`SCC_CS_BCAST] && ch_tgt_out == 2'h0
    |-> ch_wr_a_out && !ch_wr_b_out) else $error("target a bad");
  a_tgt_b_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && chan_sel && !st_r.chsel_r[`SCC_CS_BCAST] && ch_tgt_out == 2'h1
    |-> ch_wr_b_out && !ch_wr_a_out) else $error("target b bad");

  // Channel select register
  a_chsel_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && addr_in == `SCC_ADDR_CHSEL
    |-> !ch_wr_a_out && !ch_wr_b_out ##1 st_r.chsel_r == $past(wdata_in))
    else $error("chsel write lost");
  a_chsel_rd: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rd_in && addr_in == `SCC_ADDR_CHSEL
    |=> rdata_out == $past(st_r.chsel_r)) else $error("chsel read bad");

  // Status flags
  a_status_ro: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    st_r.ee_done_r |=> st_r.ee_done_r) else $error("status cleared");
  a_status_wr_ign: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_in && shared_sel && addr_in == `SCC_ADDR_STATUS && !ee_load_done_in
    |=> st_r.ee_done_r == $past(st_r.ee_done_r)) else $error("status written");

  c_bcast: cover property (@(posedge mclk_in) ch_wr_a_out && ch_wr_b_out);
  c_strap_rd: cover property (@(posedge mclk_in) rd_in && shared_sel &&
    addr_in == `SCC_ADDR_STRAP_OBS && diag_open);
  c_chan_rd: cover property (@(posedge mclk_in) ch_rd_out);
  c_lock_inv: cover property (@(posedge mclk_in) rst_b_in && strap_pol &&
    lock_fld == `SCC_LOCK_AND);
  c_pin_irq: cover property (@(posedge mclk_in) rst_b_in && st_r.chsel_r[`SCC_CS_PIN_IRQ]);
endmodule : scc_shared_ctrl
`default_nettype wire

// *** testbench/scc_chan_model.sv ***
// Purpose: Per-channel register sets behind the shared block
// Assumes: Read data combinational in the read cycle
// Notes: Target 0 is channel A, 1 is channel B
`timescale 1ns/100ps
`default_nettype none
module scc_chan_model (
  input  wire logic       mclk_in,
  input  wire logic       wr_a_in,
  input  wire logic       wr_b_in,
  input  wire logic       rd_in,
  input  wire logic [1:0] tgt_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic [7:0]      rdata_out
);
  logic [7:0] mem_a [256];
  logic [7:0] mem_b [256];
  always @(posedge mclk_in) begin
    if (wr_a_in) mem_a[addr_in] <= wdata_in;
    if (wr_b_in) mem_b[addr_in] <= wdata_in;
  end
  // Junk outside reads
  assign rdata_out = !rd_in ? ~wdata_in : (tgt_in[0] ? mem_b[addr_in] : mem_a[addr_in]);
endmodule : scc_chan_model
`default_nettype wire

// *** testbench/scc_shared_ctrl_test.sv ***
// Purpose: Register sequence tests of the shared control block
// Assumes: Strap 4'h6, then 4'h1 for strap_high; lock A up, lock B down
// Notes: Channel sets modelled by scc_chan_model
`timescale 1ns/100ps
`default_nettype none
module scc_shared_ctrl_test;
  logic mclk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0, ee = 0, ia = 0, ib = 0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata, ch_rdata;
  logic cwa, cwb, crd, lba, lab, lock, pin;
  logic [1:0] tgt;
  logic [3:0] strap = 4'h6;
  int err_total = 0, num_checks = 0;
  always #2 mclk_in = ~mclk_in;
  scc_shared_ctrl i_scc_shared_ctrl (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .addr_strap_in(strap), .wr_in(wr_in), .rd_in(rd_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .ch_rdata_in(ch_rdata), .ee_load_done_in(ee), .irq_a_in(ia),
    .irq_b_in(ib), .lock_a_in(1'b1), .lock_b_in(1'b0), .sig_absent_in(1'b0),
    .irq_in(1'b1), .rdata_out(rdata), .ch_wr_a_out(cwa), .ch_wr_b_out(cwb),
    .ch_rd_out(crd), .ch_tgt_out(tgt), .lb_b_to_a_out(lba), .lb_a_to_b_out(lab),
    .lock_pin_out(lock), .signal_loss_or_irq_pin_out(pin));
  scc_chan_model i_scc_chan_model (.mclk_in(mclk_in), .wr_a_in(cwa), .wr_b_in(cwb),
    .rd_in(crd), .tgt_in(tgt), .addr_in(addr_in), .wdata_in(wdata_in),
    .rdata_out(ch_rdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in) begin wr_in <= 1; addr_in <= a; wdata_in <= d; end
    @(posedge mclk_in) wr_in <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in) begin rd_in <= 1; addr_in <= a; end
    @(posedge mclk_in) rd_in <= 0;
    #1 chk("rdata", e, rdata);
  endtask : rd
  task automatic wt;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask : wt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #8000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1;
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h04);
    rd(8'hFF, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h06, 8'h0A);
    rd(8'h00, 8'h60);
    $display("test reset_strap done");
    @(posedge mclk_in) begin ee <= 1; ia <= 1; ib <= 1; end
    @(posedge mclk_in) begin ee <= 0; ia <= 0; ib <= 0; end
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h1C);
    wr(8'h07, 8'h02);
    chk("loopback", 8'h02, {6'h00, lba, lab});
    $display("test flags_loopback done");
    for (int f = 0; f < 4; f++) begin
      wr(8'((f << 6)), 8'((f << 6)));
      wr(8'hFF, 8'((f << 6)));
      wt();
      chk("lock_pin", 8'(f < 2), {7'h00, lock});
    end
    wr(8'hFF, 8'h20);
    wt();
    chk("pin_fn", 8'h01, {7'h00, pin});
    wr(8'hFF, 8'h00);
    wt();
    chk("pin_fn", 8'h00, {7'h00, pin});
    $display("test pins done");
    wr(8'hFF, 8'h0D);
    wr(8'h10, 8'h5A);
    wr(8'hFF, 8'h05);
    chk("target", 8'h01, {6'h00, tgt});
    rd(8'h10, 8'h5A);
    wr(8'h10, 8'h33);
    rd(8'h10, 8'h33);
    wr(8'hFF, 8'h04);
    rd(8'h10, 8'h5A);
    wr(8'hFF, 8'h00);
    rd(8'h07, 8'h02);
    $display("test routing done");
    @(posedge mclk_in) begin rst_b_in <= 0; strap <= 4'h1; end
    repeat (2) @(posedge mclk_in);
    @(posedge mclk_in) rst_b_in <= 1;
    rd(8'h07, 8'h04);
    wt();
    chk("lock_pin", 8'h00, {7'h00, lock});
    wr(8'hFF, 8'hC0);
    wt();
    chk("lock_pin", 8'h01, {7'h00, lock});
    wr(8'hFF, 8'h40);
    wt();
    chk("lock_pin", 8'h00, {7'h00, lock});
    wr(8'hFF, 8'h80);
    wt();
    chk("lock_pin", 8'h01, {7'h00, lock});
    $display("test strap_high done");
    print_verdict();
  end
endmodule : scc_shared_ctrl_test
`default_nettype wire
